/* hdl/dbgfb_pkg.sv */
package dbgfb_pkg;
  // ---------------------------------------------------------------
  // Register map (register index; byte address = 4*index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_FLAG = 8'h1B;
  localparam logic [7:0] IDX_BUF = 8'h1C;
  localparam logic [7:0] IDX_ADDR = 8'h1D;
  localparam logic [7:0] IDX_DATA = 8'h1E;
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h21;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h22;
  localparam logic [7:0] IDX_STATUS = 8'h23;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FLAG_XFER_DONE = 0;
  localparam int FLAG_PROG_EN = 1;
  localparam int FLAG_SS_LO = 2;
  localparam int CTRL_DBG_EN = 0;
  localparam int CTRL_REG_BRK = 1;
  localparam int CTRL_ROMDONE = 2;
  localparam int IRQ_XFER = 0;
  localparam int IRQ_BREAK = 1;
  localparam int IRQ_TLR = 2;
  localparam int IRQ_W = 3;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_FLAG = 8'h00;
  localparam logic [7:0] RST_BUF = 8'h00;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [15:0] RST_DATA = 16'h0000;
  // ---------------------------------------------------------------
  // Source select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SS_TEST_PORT = 2'h0;
  localparam logic [1:0] SS_I2C = 2'h1;
  // Boot path decision
  typedef enum logic [1:0] {BOOT_USER, BOOT_ISP_TEST, BOOT_ISP_I2C, BOOT_EXIT} dbgfb_boot_t;
  // Link update from the TAP shift logic
  typedef struct packed {
    logic [7:0] shift_byte;
    logic [15:0] addr;
    logic [15:0] data;
  } dbgfb_link_t;
  // CPU destination register write observed for breakpoints
  typedef struct packed {
    logic valid;
    logic addr_hit;
    logic [15:0] data;
  } dbgfb_dst_t;
endpackage : dbgfb_pkg

/* hdl/dbgfb_regs.sv */
`timescale 1ns/1ns
// Functional notes
// RL1: Source select: 00 test, 01 I2C, 1x exit
// RL2: Enable reads as OR with buffer enable
// RL3: Enable clears on reset, TLR, ROM done
// RL4: Enable or flag writes clear source select
// RL5: Link transfer end sets transfer flag only with a same-cycle flag write
// RL6: ROM sets flag; engine clears it
// RL7: Enable 1 means ISP, else user
// RL8: Byte buffer holds debug shift byte
// RL9: Address register written by engine only
// RL10: Set mask bits join data compare
// RL11: Cleared mask bits are don't care
// RL12: Zero mask breaks on any write
// RL13: Data register written by engine only
// RL14: Data register supplies match pattern
// RL15: Boot ROM always runs first after reset
// RL16: No break without debug mode enable
// RL17: Break needs register-break enable and match
// RL18: Reserved flag bits read zero
module dbgfb_regs (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Test port side (link clock domain, sampled here)
  input wire logic tck,
  input wire logic update_dr,
  input wire logic test_logic_reset,
  input wire logic buffer_program_enable,
  input wire dbgfb_pkg::dbgfb_link_t link_in,
  output dbgfb_pkg::dbgfb_link_t link_out,
  output logic link_status,
  // Breakpoint watch
  input wire dbgfb_pkg::dbgfb_dst_t dst_write,
  output logic break_req,
  // Boot path
  output dbgfb_pkg::dbgfb_boot_t boot_path,
  output logic boot_rom_first,
  // Interrupt
  output logic irq
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam int IRQ_W = dbgfb_pkg::IRQ_W;
  // Hazard: link pins are asynchronous to core_clk
  // Update seen 2 to 3 core cycles after link clock falls
  // Link clock must stay well below a quarter of core_clk

  // Link pin synchronisers and edge history
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic tck_s; // Synchronised link clock
  logic upd_s; // Synchronised update state
  logic tlr_s; // Synchronised test-logic reset
  logic buf_en_s; // Synchronised buffer enable
  logic tck_q;
  logic tlr_q;
  logic upd_fall;
  logic tlr_rise;

  // Software-visible registers
  logic [7:0] flag_reg;
  logic [7:0] byte_buffer;
  logic [15:0] address_mask;
  logic [15:0] data_pattern;
  logic [2:0] ctrl_reg;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;

  // Bus decode and write strobes
  logic wb_hit;
  logic wr_en;
  logic [7:0] idx;
  logic wr_flag; // Flag register write
  logic wr_buf; // Byte buffer write
  logic wr_ctrl; // Control register write
  logic wr_irq_stat; // Status write-one-clear
  logic wr_irq_mask; // Interrupt mask write

  // Derived state
  logic prog_en_read;
  logic rom_done_set;
  logic bp_armed;
  logic bp_write;
  logic bp_match;
  logic bp_hit;
  logic [IRQ_W-1:0] irq_evt;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------

  // Two flops for each link control pin; link_in is not synchronised
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {buffer_program_enable, test_logic_reset, update_dr, tck};
      sync2 <= sync1;
    end
  end

  // Named views of the synchronised pins
  assign tck_s = sync2[0];
  assign upd_s = sync2[1];
  assign tlr_s = sync2[2];
  assign buf_en_s = sync2[3];

  // Edge history of synchronised link signals
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tck_q <= 1'b0;
      tlr_q <= 1'b0;
    end else begin
      tck_q <= tck_s;
      tlr_q <= tlr_s;
    end
  end

  // Update happens on falling link clock while in update state
  assign upd_fall = tck_q & ~tck_s & upd_s;
  assign tlr_rise = tlr_s & ~tlr_q;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign idx = wb_adr_i[9:2];
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = wb_hit & wb_we_i & wb_sel_i[0];

  // Write aimed at one register index
  function automatic logic dbgfb_wr_to(input logic en, input logic [7:0] at,
                                       input logic [7:0] want);
    dbgfb_wr_to = en && (at == want);
  endfunction : dbgfb_wr_to

  // Per-register write strobes
  assign wr_flag = dbgfb_wr_to(wr_en, idx, dbgfb_pkg::IDX_FLAG);
  assign wr_buf = dbgfb_wr_to(wr_en, idx, dbgfb_pkg::IDX_BUF);
  assign wr_ctrl = dbgfb_wr_to(wr_en, idx, dbgfb_pkg::IDX_CTRL);
  assign wr_irq_stat = dbgfb_wr_to(wr_en, idx, dbgfb_pkg::IDX_IRQ_STAT);
  assign wr_irq_mask = dbgfb_wr_to(wr_en, idx, dbgfb_pkg::IDX_IRQ_MASK);

  // One-cycle acknowledge; drops next cycle so a held request is taken once
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  // RL2: OR of enables
  assign prog_en_read = flag_reg[dbgfb_pkg::FLAG_PROG_EN] | buf_en_s;

  // Read data register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_hit && !wb_we_i) begin
      case (idx)
        // RL18: reserved read zero
        dbgfb_pkg::IDX_FLAG: wb_dat_o <= {28'h0000000, flag_reg[3:2], prog_en_read, flag_reg[0]};
        dbgfb_pkg::IDX_BUF: wb_dat_o <= {24'h000000, byte_buffer};
        // Engine-written registers
        dbgfb_pkg::IDX_ADDR: wb_dat_o <= {16'h0000, address_mask};
        dbgfb_pkg::IDX_DATA: wb_dat_o <= {16'h0000, data_pattern};
        // Control and interrupt registers
        dbgfb_pkg::IDX_CTRL: wb_dat_o <= {29'h0000000, ctrl_reg};
        dbgfb_pkg::IDX_IRQ_STAT: wb_dat_o <= {29'h0000000, irq_stat};
        dbgfb_pkg::IDX_IRQ_MASK: wb_dat_o <= {29'h0000000, irq_mask};
        // Live status
        dbgfb_pkg::IDX_STATUS: wb_dat_o <= {30'h0000000, bp_hit, upd_fall};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Flag register
  // ---------------------------------------------------------------
  // ROM done rising, seen as a control write
  assign rom_done_set = wr_ctrl && wb_dat_i[dbgfb_pkg::CTRL_ROMDONE]
    && !ctrl_reg[dbgfb_pkg::CTRL_ROMDONE];

  // Source select, enable and transfer flag; later statements win
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= dbgfb_pkg::RST_FLAG;
    end else begin
      // RL6: engine clears flag at update
      if (upd_fall) begin
        flag_reg[dbgfb_pkg::FLAG_XFER_DONE] <= 1'b0;
      end
      // Software write overrides the update clear
      if (wr_flag) begin
        // RL4: writes clear select
        flag_reg[3:2] <= 2'h0;
        flag_reg[dbgfb_pkg::FLAG_PROG_EN] <= wb_dat_i[dbgfb_pkg::FLAG_PROG_EN];
        // RL6: ROM sets transfer flag
        flag_reg[dbgfb_pkg::FLAG_XFER_DONE] <= wb_dat_i[dbgfb_pkg::FLAG_XFER_DONE];
      end else if (wr_ctrl && wb_dat_i[3]) begin
        // RL1: boot ROM selects source
        flag_reg[3:2] <= wb_dat_i[5:4];
      end
      // RL5: transfer end sets flag only with a same-cycle flag write
      if (upd_fall && wr_flag) begin
        flag_reg[dbgfb_pkg::FLAG_XFER_DONE] <= 1'b1;
      end
      // RL3: ROM done or TLR clears enable
      // Clear wins over a same-cycle software set
      if (rom_done_set || tlr_s) begin
        flag_reg[dbgfb_pkg::FLAG_PROG_EN] <= 1'b0;
      end
      // RL18: reserved bits stay zero
      flag_reg[7:4] <= 4'h0;
    end
  end

  // Control: debug mode, register break, ROM done
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= 3'h0;
    end else if (wr_ctrl) begin
      ctrl_reg <= wb_dat_i[2:0];
    end
  end

  // ---------------------------------------------------------------
  // Link registers
  // ---------------------------------------------------------------
  // RL8: byte buffer swap at update
  // Host gets the old byte while the new one lands
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      byte_buffer <= dbgfb_pkg::RST_BUF;
      link_out <= '0;
    end else if (upd_fall) begin
      byte_buffer <= link_in.shift_byte;
      link_out <= '{
        shift_byte: byte_buffer,
        addr: address_mask,
        data: data_pattern
      };
    end else if (wr_buf) begin
      byte_buffer <= wb_dat_i[7:0];
    end
  end

  // RL9: engine-written address
  // RL13: engine-written data
  // Frozen once ROM code is done
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      address_mask <= dbgfb_pkg::RST_ADDR;
      data_pattern <= dbgfb_pkg::RST_DATA;
    end else if (upd_fall && !ctrl_reg[dbgfb_pkg::CTRL_ROMDONE]) begin
      address_mask <= link_in.addr;
      data_pattern <= link_in.data;
    end
  end

  // Transfer flag driven to host as status
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      link_status <= 1'b0;
    end else begin
      link_status <= flag_reg[dbgfb_pkg::FLAG_XFER_DONE];
    end
  end

  // ---------------------------------------------------------------
  // Register breakpoint
  // ---------------------------------------------------------------
  // RL10: masked compare
  // RL11: clear bits ignored
  // RL12: zero mask always hits
  // RL14: data is pattern
  function automatic logic dbgfb_match(input logic [15:0] m, input logic [15:0] p,
                                       input logic [15:0] d);
    dbgfb_match = ((p ^ d) & m) == 16'h0000;
  endfunction : dbgfb_match

  // RL16: gated by debug mode
  // RL17: needs register-break enable
  assign bp_armed = ctrl_reg[dbgfb_pkg::CTRL_DBG_EN] & ctrl_reg[dbgfb_pkg::CTRL_REG_BRK];
  // Destination written at breakpoint address
  assign bp_write = dst_write.valid & dst_write.addr_hit;
  // Masked pattern compare of written data
  assign bp_match = dbgfb_match(address_mask, data_pattern, dst_write.data);
  // Break only when armed, written and matched
  assign bp_hit = bp_armed & bp_write & bp_match;

  // Break request register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      break_req <= 1'b0;
    end else begin
      break_req <= bp_hit;
    end
  end

  // ---------------------------------------------------------------
  // Boot path
  // ---------------------------------------------------------------
  // RL7: enable steers boot path
  // RL1: select decoded
  // Select only counts while enable reads one
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      boot_path <= dbgfb_pkg::BOOT_USER;
    end else if (!prog_en_read) begin
      boot_path <= dbgfb_pkg::BOOT_USER;
    end else if (flag_reg[3]) begin
      boot_path <= dbgfb_pkg::BOOT_EXIT;
    end else if (flag_reg[2]) begin
      boot_path <= dbgfb_pkg::BOOT_ISP_I2C;
    end else begin
      boot_path <= dbgfb_pkg::BOOT_ISP_TEST;
    end
  end

  // RL15: ROM runs until done
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      boot_rom_first <= 1'b1;
    end else begin
      boot_rom_first <= ~ctrl_reg[dbgfb_pkg::CTRL_ROMDONE];
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  // Event sources, one per status bit
  assign irq_evt[dbgfb_pkg::IRQ_XFER] = upd_fall;
  assign irq_evt[dbgfb_pkg::IRQ_BREAK] = bp_hit;
  assign irq_evt[dbgfb_pkg::IRQ_TLR] = tlr_rise;

  // Sticky status, set wins over write-one clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= '0;
    end else begin
      // Clear first, then events, so no event is lost
      if (wr_irq_stat) begin
        irq_stat <= (irq_stat & ~wb_dat_i[IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat <= irq_stat | irq_evt;
      end
    end
  end

  // Mask register
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask <= '0;
    end else if (wr_irq_mask) begin
      irq_mask <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // Level interrupt: any unmasked status bit
  assign irq = |(irq_stat & irq_mask);
endmodule : dbgfb_regs

/* verif/dbgfb_link_host.sv */
`timescale 1ns/1ns
module dbgfb_link_host (
  // Test port lines
  output logic tck,
  output logic update_dr,
  output logic test_logic_reset,
  output logic buffer_program_enable,
  output dbgfb_pkg::dbgfb_link_t link_in
);
  // Lines idle low, clock still
  initial begin
    {tck, update_dr, test_logic_reset, buffer_program_enable} = 4'h0;
    link_in = '0;
  end
  // Static level lines
  task automatic lines(input logic t, input logic b);
    test_logic_reset = t;
    buffer_program_enable = b;
  endtask : lines
  // One shift clock, then the update clock
  task automatic xfer(input logic [39:0] v);
    link_in = v;
    #160 tck = 1'b1;
    #160 tck = 1'b0;
    #80 update_dr = 1'b1;
    #80 tck = 1'b1;
    #160 tck = 1'b0;
    #320 update_dr = 1'b0;
    link_in = ~v; // Released lines show no stale data
  endtask : xfer
endmodule : dbgfb_link_host

/* verif/dbgfb_regs_chk.sv */
`timescale 1ns/1ns
module dbgfb_regs_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Link lines and watch
  input wire logic test_logic_reset,
  input wire logic buffer_program_enable,
  input wire dbgfb_pkg::dbgfb_dst_t dst_write,
  input wire logic break_req,
  input wire logic boot_rom_first
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic wr_ok, rd_flag, hit, debug_mode_enable, break_on_register_enable, ss_clr;
  assign wr_ok = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  assign rd_flag = wb_ack_o && wb_stb_i && !wb_we_i && wb_adr_i[9:2] == dbgfb_pkg::IDX_FLAG;
  assign hit = dst_write.valid && dst_write.addr_hit;
  // Shadow of control bits and select state
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      {debug_mode_enable, break_on_register_enable, ss_clr} <= 3'h1;
    end else if (wr_ok && wb_adr_i[9:2] == dbgfb_pkg::IDX_CTRL) begin
      {debug_mode_enable, break_on_register_enable} <= {wb_dat_i[0], wb_dat_i[1]};
      ss_clr <= ss_clr && !wb_dat_i[3];
    end else if (wr_ok && wb_adr_i[9:2] == dbgfb_pkg::IDX_FLAG) begin
      ss_clr <= 1'b1;
    end
  end
  chk_rsv_zero: assert property (rd_flag |-> wb_dat_o[7:4] == 4'h0)
    else $error("flag reserved bits set");
  chk_spe_or: assert property (buffer_program_enable [*6] ##0 rd_flag |-> wb_dat_o[1])
    else $error("enable ignores buffer bit");
  chk_tlr_clears: assert property
    ((test_logic_reset && !buffer_program_enable) [*6] ##0 rd_flag |-> !wb_dat_o[1])
    else $error("enable survives test reset");
  chk_ss_cleared: assert property (rd_flag && ss_clr |-> wb_dat_o[3:2] == 2'h0)
    else $error("select not cleared");
  chk_brk_dme: assert property (break_req |-> $past(debug_mode_enable))
    else $error("break without debug mode");
  chk_brk_break_on_register_enable: assert property (break_req |-> $past(break_on_register_enable))
    else $error("break without register enable");
  chk_brk_cause: assert property (break_req |-> $past(hit))
    else $error("break without destination write");
  chk_rom_first: assert property ($rose(resetn) |-> boot_rom_first)
    else $error("boot code not first");
  cover property (buffer_program_enable [*6] ##0 rd_flag);
  cover property (test_logic_reset [*6] ##0 rd_flag);
  cover property (break_req);
endmodule : dbgfb_regs_chk

/* verif/test_debug_flag_buffer_breakpoint_regs.sv */
`timescale 1ns/1ns
module test_debug_flag_buffer_breakpoint_regs;
  logic core_clk, resetn, cyc, stb, we, ack, tck, upd, tlr, bpe, lstat, brk, first, irq;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  dbgfb_pkg::dbgfb_link_t lin, lout;
  dbgfb_pkg::dbgfb_dst_t dst;
  dbgfb_pkg::dbgfb_boot_t boot;
  int num_errors, check_count;
  // Device and far-side host
  dbgfb_regs u_dut (.core_clk(core_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .tck(tck), .update_dr(upd), .test_logic_reset(tlr),
    .buffer_program_enable(bpe), .link_in(lin), .link_out(lout), .link_status(lstat),
    .dst_write(dst), .break_req(brk), .boot_path(boot), .boot_rom_first(first), .irq(irq));
  dbgfb_link_host u_host (.tck(tck), .update_dr(upd), .test_logic_reset(tlr),
    .buffer_program_enable(bpe), .link_in(lin));
  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Value compare
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  // Classic bus cycle, held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge core_clk);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, i, 2'h0, d};
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'h0;
    @(negedge core_clk);
  endtask : wb
  task automatic rd(input logic [7:0] i, input logic [31:0] e);
    wb(1'b0, i, 32'h0);
    cmp($sformatf("reg %h", i), e, q);
  endtask : rd
  // One destination write, break seen within two cycles
  task automatic hit(input logic [15:0] d, input logic e);
    logic s;
    @(posedge core_clk);
    dst <= '{1'b1, 1'b1, d};
    @(posedge core_clk);
    dst <= '0;
    @(negedge core_clk);
    s = brk;
    @(negedge core_clk);
    cmp("break", {31'h0, e}, {31'h0, s | brk});
  endtask : hit
  // Reset values and read-only places
  task automatic t_reset();
    rd(8'h1B, 32'h0);
    rd(8'h1C, 32'h0);
    rd(8'h1D, 32'h0);
    rd(8'h1E, 32'h0);
    rd(8'h1F, 32'h0);
    cmp("first", 32'h1, {31'h0, first});
  endtask : t_reset
  // Flag fields and boot path
  task automatic t_flag();
    wb(1'b1, 8'h1B, 32'hFF);
    rd(8'h1B, 32'h03);
    wb(1'b1, 8'h20, 32'h18);
    rd(8'h1B, 32'h07);
    cmp("boot", {30'h0, dbgfb_pkg::BOOT_ISP_I2C}, {30'h0, boot});
    wb(1'b1, 8'h20, 32'h28);
    rd(8'h1B, 32'h0B);
    cmp("boot", {30'h0, dbgfb_pkg::BOOT_EXIT}, {30'h0, boot});
    wb(1'b1, 8'h1B, 32'h01);
    rd(8'h1B, 32'h01);
    cmp("status", 32'h1, {31'h0, lstat});
    cmp("boot", {30'h0, dbgfb_pkg::BOOT_USER}, {30'h0, boot});
    wb(1'b1, 8'h1D, 32'hFFFF);
    rd(8'h1D, 32'h0);
  endtask : t_flag
  // Link transfer, buffer swap, interrupt
  task automatic t_link();
    wb(1'b1, 8'h22, 32'h01);
    wb(1'b1, 8'h1C, 32'h3C);
    u_host.xfer({8'hA5, 16'h00FF, 16'h1234});
    repeat (8) @(negedge core_clk);
    cmp("out", 32'h3C, {24'h0, lout.shift_byte});
    cmp("irq", 32'h1, {31'h0, irq});
    cmp("status", 32'h0, {31'h0, lstat});
    rd(8'h1C, 32'hA5);
    rd(8'h1D, 32'h00FF);
    rd(8'h1E, 32'h1234);
  endtask : t_link
  // Mask and pattern matching, masked interrupt
  task automatic t_break();
    wb(1'b1, 8'h20, 32'h03);
    hit(16'hFF34, 1'b1);
    hit(16'h1235, 1'b0);
    wb(1'b1, 8'h20, 32'h02);
    hit(16'h1234, 1'b0);
    wb(1'b1, 8'h20, 32'h01);
    hit(16'h1234, 1'b0);
    u_host.xfer(40'h0);
    wb(1'b1, 8'h20, 32'h03);
    hit(16'hABCD, 1'b1);
    wb(1'b1, 8'h21, 32'h01);
    cmp("irq", 32'h0, {31'h0, irq});
    rd(8'h21, 32'h02);
    wb(1'b1, 8'h22, 32'h02);
    cmp("irq", 32'h1, {31'h0, irq});
    wb(1'b1, 8'h21, 32'h02);
    cmp("irq", 32'h0, {31'h0, irq});
  endtask : t_break
  // Enable sources and clearing
  task automatic t_spe();
    wb(1'b1, 8'h1B, 32'h02);
    rd(8'h1B, 32'h02);
    cmp("boot", {30'h0, dbgfb_pkg::BOOT_ISP_TEST}, {30'h0, boot});
    u_host.lines(1'b1, 1'b0);
    repeat (8) @(negedge core_clk);
    rd(8'h1B, 32'h0);
    u_host.lines(1'b0, 1'b1);
    repeat (8) @(negedge core_clk);
    rd(8'h1B, 32'h02);
    u_host.lines(1'b0, 1'b0);
    wb(1'b1, 8'h1B, 32'h02);
    wb(1'b1, 8'h20, 32'h04);
    rd(8'h1B, 32'h0);
    cmp("first", 32'h0, {31'h0, first});
  endtask : t_spe
  task automatic close_out();
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    {resetn, cyc, stb, we, adr, wdat} = '0;
    sel = 4'h1;
    dst = '0;
    {num_errors, check_count} = '0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_flag();
    t_link();
    t_break();
    t_spe();
    close_out();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    close_out();
  end
endmodule : test_debug_flag_buffer_breakpoint_regs
bind dbgfb_regs dbgfb_regs_chk u_chk (.core_clk(core_clk), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .test_logic_reset(test_logic_reset), .buffer_program_enable(buffer_program_enable),
  .dst_write(dst_write), .break_req(break_req), .boot_rom_first(boot_rom_first));
